/* design/pbsp_pkg.sv */
// package: constants and types for the pipelined burst sram port
package pbsp_pkg;
   localparam int ADDR_W      = 15;
   localparam int LANES       = 4;
   localparam int LANE_W      = 9;
   localparam int DATA_W      = LANES * LANE_W;
   localparam int BURST_W     = 2;
   // sleep entry and exit times, in clock periods
   localparam int SLEEP_ENTRY_CYC = 2;
   localparam int SLEEP_EXIT_CYC  = 2;
   localparam logic [1:0] SLEEP_CNT_ZERO = 2'h0;
   localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;
   localparam logic [BURST_W-1:0] STEP_ZERO = 2'h0;
   typedef enum logic [1:0] {
      PBSP_AWAKE    = 2'b00,
      PBSP_ENTERING = 2'b01,
      PBSP_ASLEEP   = 2'b10,
      PBSP_LEAVING  = 2'b11
   } pbsp_sleep_t;
endpackage

/* design/pbsp_core.sv */
// pipelined single-cycle-deselect burst sram access logic
`timescale 1ns/10ps
module pbsp_core
   import pbsp_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   input  wire logic          sys_clk_i,
   input  wire logic          srst_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [DW-1:0] dq_i,
   output logic      [DW-1:0] dq_o,
   output logic      [DW-1:0] dq_oe_o,
   input  wire logic          primary_chip_sel_n_i,
   input  wire logic          expansion_chip_sel_i,
   input  wire logic          expansion_chip_sel2_n_i,
   input  wire logic          processor_addr_strobe_n_i,
   input  wire logic          controller_addr_strobe_n_i,
   input  wire logic          burst_step_n_i,
   input  wire logic          all_bytes_write_n_i,
   input  wire logic          lane_write_enable_n_i,
   input  wire logic [3:0]    lane_select_n_i,
   input  wire logic          output_enable_n_i,
   input  wire logic          sleep_request_i,
   input  wire logic          burst_order_i,
   output logic               sleeping_o
);
   localparam int DEPTH = 1 << AW;
   localparam int LW    = DW / LANES;

   // ------------------------------------------------------------------
   // input registers
   // ------------------------------------------------------------------
   logic [AW-1:0]      addr_q;
   logic [DW-1:0]      din_q;
   logic               pri_sel_n_q;
   logic               exp_sel_q;
   logic               exp_sel2_n_q;
   logic               pstrobe_n_q;
   logic               cstrobe_n_q;
   logic               step_n_q;
   logic               allw_n_q;
   logic               lanew_n_q;
   logic [LANES-1:0]   lanesel_n_q;

   // address and write data
   always_ff @(posedge sys_clk_i) begin
      addr_q <= addr_i;
      din_q  <= dq_i;
   end

   // chip selects
   always_ff @(posedge sys_clk_i) begin
      pri_sel_n_q  <= primary_chip_sel_n_i;
      exp_sel_q    <= expansion_chip_sel_i;
      exp_sel2_n_q <= expansion_chip_sel2_n_i;
   end

   // address strobes and burst step
   always_ff @(posedge sys_clk_i) begin
      pstrobe_n_q <= processor_addr_strobe_n_i;
      cstrobe_n_q <= controller_addr_strobe_n_i;
      step_n_q    <= burst_step_n_i;
   end

   // write controls
   always_ff @(posedge sys_clk_i) begin
      allw_n_q    <= all_bytes_write_n_i;
      lanew_n_q   <= lane_write_enable_n_i;
      lanesel_n_q <= lane_select_n_i;
   end

   // ------------------------------------------------------------------
   // synchronisers for the asynchronous pins
   // ------------------------------------------------------------------
   // output enable, sleep request and strap come from outside the clock
   // domain, so each passes two flops before any logic reads it
   logic               oe_n_m;
   logic               oe_n_s;
   logic               sleep_m;
   logic               sleep_s;
   logic               mode_m;
   logic               mode_s;

   always_ff @(posedge sys_clk_i) begin
      oe_n_m <= output_enable_n_i;
      oe_n_s <= oe_n_m;
   end

   always_ff @(posedge sys_clk_i) begin
      sleep_m <= sleep_request_i;
      sleep_s <= sleep_m;
   end

   always_ff @(posedge sys_clk_i) begin
      mode_m <= burst_order_i;
      mode_s <= mode_m;
   end

   // ------------------------------------------------------------------
   // burst order strap
   // ------------------------------------------------------------------
   // caught once after reset release and then held, so a strap that
   // moves during operation cannot reorder a running burst
   logic               mode_taken;
   logic               mode;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         mode_taken <= 1'b0;
         mode       <= 1'b1;
      end else if (!mode_taken) begin
         mode_taken <= 1'b1;
         mode       <= mode_s;
      end
   end

   // ------------------------------------------------------------------
   // command decode on registered inputs
   // ------------------------------------------------------------------
   pbsp_sleep_t        sleep_st;
   pbsp_sleep_t        next_sleep_st;
   logic               awake;
   logic               active;
   logic               selected;
   logic               pstrobe_act;
   logic               cstrobe_act;
   logic               strobe;
   logic               start_acc;
   logic               deselect;
   logic               any_write;
   logic               start_wr;
   logic               continue_c;
   logic               cont_wr;
   logic               do_wr;
   logic [LANES-1:0]   lane_we;

   assign awake       = (sleep_st == PBSP_AWAKE);
   assign selected    = !pri_sel_n_q && exp_sel_q && !exp_sel2_n_q;
   assign pstrobe_act = !pstrobe_n_q && !pri_sel_n_q;
   assign cstrobe_act = !cstrobe_n_q && !pstrobe_act;
   assign strobe      = awake && (pstrobe_act || cstrobe_act);
   assign start_acc   = strobe && selected;
   assign deselect    = strobe && !selected;

   // global write forces every lane, otherwise the lane selects decide
   for (genvar g = 0; g < LANES; g++) begin : g_lane_we
      assign lane_we[g] = !allw_n_q || (!lanew_n_q && !lanesel_n_q[g]);
   end
   assign any_write   = |lane_we;

   // processor strobe always starts as a read, writes ignored that cycle
   assign start_wr    = start_acc && cstrobe_act && any_write;
   assign continue_c  = awake && !strobe && active;
   assign cont_wr     = continue_c && any_write;
   assign do_wr       = start_wr || cont_wr;

   // ------------------------------------------------------------------
   // burst counter
   // ------------------------------------------------------------------
   logic [AW-1:0]      base;
   logic [BURST_W-1:0] step;
   logic [BURST_W-1:0] next_step;
   logic [BURST_W-1:0] burst_lo;
   logic [AW-1:0]      acc_addr;
   logic               advance;

   assign advance   = continue_c && !step_n_q;
   // a fresh strobe restarts the count, no step holds the address
   assign next_step = start_acc ? STEP_ZERO :
                      (advance ? step + STEP_ONE : step);
   assign burst_lo  = mode ? (base[BURST_W-1:0] ^ next_step)
                           : (base[BURST_W-1:0] + next_step);
   assign acc_addr  = start_acc ? addr_q : {base[AW-1:BURST_W], burst_lo};

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         base <= '0;
         step <= STEP_ZERO;
      end else begin
         if (start_acc) begin
            base <= addr_q;
         end
         step <= next_step;
      end
   end

   // a deselect or any sleep phase ends the burst and drops what is pending
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         active <= 1'b0;
      end else if (start_acc) begin
         active <= 1'b1;
      end else if (deselect || !awake) begin
         active <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // memory array and output register
   // ------------------------------------------------------------------
   // the array has no reset: contents survive reset and sleep alike
   logic [DW-1:0]      mem [DEPTH];
   logic [DW-1:0]      rd_q;

   always_ff @(posedge sys_clk_i) begin
      for (int l = 0; l < LANES; l++) begin
         if (do_wr && lane_we[l]) begin
            mem[acc_addr][l*LW +: LW] <= din_q[l*LW +: LW];
         end
      end
   end

   // the array is read every cycle; the enable pipeline decides what shows
   always_ff @(posedge sys_clk_i) begin
      rd_q <= mem[acc_addr];
   end

   // ------------------------------------------------------------------
   // output enable pipeline
   // ------------------------------------------------------------------
   // sel_p clears one edge after a deselect, so the deselect's own slot is not driven
   logic               sel_p;
   logic               first_c;
   logic               wr_c;
   logic               next_oe;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         sel_p   <= 1'b0;
         first_c <= 1'b0;
         wr_c    <= 1'b0;
      end else begin
         sel_p   <= active && !(deselect || !awake);
         first_c <= start_acc && !active;
         wr_c    <= do_wr;
      end
   end

   // the enable pin is synchronised, so a change shows two edges late
   assign next_oe = sel_p && !first_c && !wr_c && !oe_n_s && awake;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         dq_o <= '0;
      end else begin
         dq_o <= rd_q;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         dq_oe_o <= '0;
      end else begin
         dq_oe_o <= {DW{next_oe}};
      end
   end

   // ------------------------------------------------------------------
   // sleep sequencer
   // ------------------------------------------------------------------
   logic [1:0]         sleep_cnt;

   always_comb begin
      next_sleep_st = sleep_st;
      case (sleep_st)
         PBSP_AWAKE: begin
            if (sleep_s) next_sleep_st = PBSP_ENTERING;
         end
         PBSP_ENTERING: begin
            if (sleep_cnt == 2'(SLEEP_ENTRY_CYC - 1)) next_sleep_st = PBSP_ASLEEP;
         end
         PBSP_ASLEEP: begin
            if (!sleep_s) next_sleep_st = PBSP_LEAVING;
         end
         PBSP_LEAVING: begin
            if (sleep_cnt == 2'(SLEEP_EXIT_CYC - 1)) next_sleep_st = PBSP_AWAKE;
         end
         default: next_sleep_st = PBSP_AWAKE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         sleep_st  <= PBSP_AWAKE;
         sleep_cnt <= SLEEP_CNT_ZERO;
      end else begin
         sleep_st  <= next_sleep_st;
         sleep_cnt <= (next_sleep_st != sleep_st) ? SLEEP_CNT_ZERO : sleep_cnt + 2'h1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         sleeping_o <= 1'b0;
      end else begin
         sleeping_o <= (next_sleep_st == PBSP_ASLEEP);
      end
   end
endmodule

/* tb/pbsp_core_asserts.sv */
// assertion checker for the burst sram port
`timescale 1ns/10ps
module pbsp_core_asserts #(parameter int AW = 15, parameter int DW = 36) (
   input logic sys_clk_i,
   input logic srst_i,
   input logic [AW-1:0] addr_i,
   input logic [DW-1:0] dq_i,
   input logic [DW-1:0] dq_o,
   input logic [DW-1:0] dq_oe_o,
   input logic primary_chip_sel_n_i,
   input logic expansion_chip_sel_i,
   input logic expansion_chip_sel2_n_i,
   input logic processor_addr_strobe_n_i,
   input logic controller_addr_strobe_n_i,
   input logic burst_step_n_i,
   input logic all_bytes_write_n_i,
   input logic lane_write_enable_n_i,
   input logic [3:0] lane_select_n_i,
   input logic output_enable_n_i,
   input logic sleep_request_i,
   input logic burst_order_i,
   input logic sleeping_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   wire sel = !primary_chip_sel_n_i && expansion_chip_sel_i && !expansion_chip_sel2_n_i;
   wire cs  = sel && !controller_addr_strobe_n_i && processor_addr_strobe_n_i;
   sequence s_rd;
      cs && all_bytes_write_n_i && lane_write_enable_n_i && !output_enable_n_i && !sleeping_o;
   endsequence
   sequence s_dsel;
      primary_chip_sel_n_i && !controller_addr_strobe_n_i;
   endsequence
   chk_oe_uniform: assert property (dq_oe_o == '0 || dq_oe_o == '1)
      else $error("drive enables differ");
   chk_write_quiet: assert property (cs && !all_bytes_write_n_i |-> ##3 !dq_oe_o[0])
      else $error("driving during write");
   chk_oe_off: assert property (output_enable_n_i [*5] |-> !dq_oe_o[0])
      else $error("driving with output enable off");
   chk_read_drive: assert property (s_rd [*6] |-> ##1 dq_oe_o[0])
      else $error("read data not driven");
   chk_dsel_off: assert property (s_dsel ##1 s_dsel |-> ##3 !dq_oe_o[0])
      else $error("driving after deselect");
   chk_sleep_in: assert property (sleep_request_i [*8] |-> sleeping_o)
      else $error("sleep not entered");
   chk_sleep_out: assert property (!sleep_request_i [*8] |-> !sleeping_o)
      else $error("sleep not left");
   chk_sleep_quiet: assert property (sleeping_o |-> !dq_oe_o[0])
      else $error("driving while asleep");
endmodule
bind pbsp_core pbsp_core_asserts #(.AW(AW), .DW(DW)) chk (.*);

/* tb/pbsp_host_bus.sv */
// shared data bus of the external controller
`timescale 1ns/10ps
module pbsp_host_bus (
   input  logic        clk_i,
   input  logic        drv_i,
   input  logic [35:0] wdata_i,
   input  logic [35:0] mem_q_i,
   input  logic [35:0] mem_oe_i,
   output logic [35:0] bus_o
);
   logic [35:0] last = 36'h0;
   // a released bus shows the inverse of its last level, never a stale copy
   assign bus_o = mem_oe_i[0] ? mem_q_i : drv_i ? wdata_i : ~last;
   always @(posedge clk_i) last <= bus_o;
endmodule

/* tb/pipelined_burst_sram_port_tb.sv */
// self-checking bench for the burst sram port
`timescale 1ns/10ps
module pipelined_burst_sram_port_tb;
   logic        sys_clk_i = 0, srst_i = 1, ce1n = 1, oen = 1, sleep_req = 0, mode = 1, drv = 0;
   logic        ce2 = 1, ce3n = 0;
   logic [14:0] ad = 15'h0000;
   logic [35:0] wd = 36'h0, dv, dq_i, dq_o, dq_oe_o, mem [0:7];
   logic [36:0] p0 = 37'h0, p1 = 37'h0, p2 = 37'h0, rq = 37'h0;
   logic [4:0]  ctl = 5'h1F;
   logic [3:0]  lsel = 4'hF, ln;
   logic [15:0] seed = 16'h003B;
   logic [1:0]  bk;
   logic        sleeping_o;
   int          n_mismatch = 0, compares = 0, cyc = 0;
   pbsp_core uut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(ad), .dq_i(dq_i),
      .dq_o(dq_o), .dq_oe_o(dq_oe_o), .primary_chip_sel_n_i(ce1n), .expansion_chip_sel_i(ce2),
      .expansion_chip_sel2_n_i(ce3n), .processor_addr_strobe_n_i(ctl[4]),
      .controller_addr_strobe_n_i(ctl[3]), .burst_step_n_i(ctl[2]),
      .all_bytes_write_n_i(ctl[1]), .lane_write_enable_n_i(ctl[0]), .lane_select_n_i(lsel),
      .output_enable_n_i(oen), .sleep_request_i(sleep_req), .burst_order_i(mode),
      .sleeping_o(sleeping_o));
   pbsp_host_bus bus (.clk_i(sys_clk_i), .drv_i(drv), .wdata_i(wd), .mem_q_i(dq_o),
      .mem_oe_i(dq_oe_o), .bus_o(dq_i));
   always #12.5 sys_clk_i = ~sys_clk_i;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task chk(input string nm, input logic [35:0] e, input logic [35:0] s);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task complete_run();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // pins go out on one edge, the read answer lands two edges after they are taken
   task step(input logic [4:0] c, input logic [2:0] pa, input logic [2:0] ea,
             input logic [3:0] b, input bit ck);
      @(posedge sys_clk_i);
      seed = lfsr(seed);
      dv = {seed[3:0], seed, ~seed};
      ctl <= c;
      ad <= {12'h000, pa};
      lsel <= b;
      wd <= dv;
      rq <= {ck, mem[ea]};
   endtask
   always @(posedge sys_clk_i) begin
      {p2, p1, p0} <= {p1, p0, rq};
      cyc <= cyc + 1;
      if (cyc == 400) begin
         n_mismatch++;
         complete_run();
      end
   end
   always @(negedge sys_clk_i) if (p2[36]) chk("dq_o", p2[35:0], dq_o);
   initial begin
      for (int m = 0; m < 2; m++) begin
         @(posedge sys_clk_i);
         mode <= m[0];
         srst_i <= 1;
         repeat (20) @(posedge sys_clk_i);
         srst_i <= 0;
         ce1n <= 0;
         oen <= 1;
         drv <= 1;
         for (int i = 4; i < 8; i++) begin
            step(5'b10100, i[2:0], i[2:0], seed[3:0], 0);
            mem[i] = dv;
         end
         ln = seed[3:0];
         step(5'b10110, 3'h5, 3'h5, ln, 0);
         for (int l = 0; l < 4; l++) if (!ln[l]) mem[5][l*9 +: 9] = dv[l*9 +: 9];
         step(5'b01000, 3'h6, 3'h6, 4'h0, 0);
         step(5'b11110, 3'h6, 3'h6, 4'hE, 0);
         mem[6][8:0] = dv[8:0];
         step(5'b00100, 3'h4, 3'h4, 4'h0, 0);
         drv <= 0;
         oen <= 0;
         repeat (3) step(5'b11111, 3'h4, 3'h4, 4'hF, 0);
         for (int i = 0; i < 8; i++) step(5'b10111, {1'b1, i[1:0]}, {1'b1, i[1:0]}, 4'hF, 1);
         for (int k = 1; k < 5; k++) begin
            bk = k > 3 ? 2'h3 : k[1:0];
            step(k > 3 ? 5'b11111 : 5'b11011, 3'h0, {1'b1, m ? 2'h3 ^ bk : 2'h3 + bk}, 4'hF, 1);
         end
         ce1n <= 1;
         step(5'b01111, 3'h5, {1'b1, m ? 2'h0 : 2'h2}, 4'hF, 1);
         repeat (2) step(5'b10111, 3'h5, 3'h5, 4'hF, 0);
         sleep_req <= 1;
         ce2 <= 0;
         ce3n <= 1;
         repeat (12) step(5'b11111, 3'h5, 3'h5, 4'hF, 0);
         sleep_req <= 0;
         @(negedge sys_clk_i);
         chk("sleeping_o", 36'h1, {35'h0, sleeping_o});
         repeat (12) step(5'b11111, 3'h5, 3'h5, 4'hF, 0);
         ce1n <= 0;
         ce2 <= 1;
         ce3n <= 0;
         @(negedge sys_clk_i);
         chk("sleeping_o", 36'h0, {35'h0, sleeping_o});
         step(5'b10111, 3'h4, 3'h4, 4'hF, 1);
         repeat (4) step(5'b11111, 3'h4, 3'h4, 4'hF, 0);
         $display("order %0d tests done", m);
      end
      complete_run();
   end
endmodule
